//--- hdl/kms_scanner.sv
`timescale 1ns/1ns
module kms_scanner #(
   parameter int OSC_DIV = 4
) (
   // System
   input wire logic clk,
   input wire logic rst,
   // Wishbone slave
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic wb_we,
   input wire logic [3:0] wb_adr,
   input wire logic [3:0] wb_sel,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack,
   // Key matrix
   output logic [5:0] scan_line,
   input wire logic [4:0] return_column,
   // Serial link
   input wire logic ce,
   input wire logic scl,
   input wire logic si,
   output logic so_out,
   output logic so_oe
);
   typedef struct packed {
      logic [2:0] s1;
      logic [2:0] s2;
      logic [4:0] c1;
      logic [4:0] c2;
      logic ce_d;
      logic scl_d;
      logic [7:0] div;
      kms_pkg::kms_state_t st;
      logic [9:0] t_cnt;
      logic [5:0] slot;
      logic [2:0] row;
      logic pass;
      logic [29:0] first;
      logic [29:0] cur;
      logic [29:0] keys;
      logic request;
      logic rd_mode;
      logic wr_mode;
      logic [30:0] sh;
      logic [7:0] wsh;
      logic [7:0] wcnt;
      logic [1:0] size;
      logic ps_a;
      logic ps_b;
      logic quarter;
      logic frame_seen;
      logic [5:0] lines;
      logic oe;
      logic ack;
      logic [31:0] dat;
   } kms_reg_t;

   kms_reg_t r;
   kms_reg_t next_r;

   logic tick;
   logic ce_v, scl_v, si_v;
   logic ce_rise, ce_fall, scl_rise, scl_fall;
   logic [29:0] sampled;
   logic [29:0] mask;
   logic [29:0] shown;
   logic psave, ps2, any_key, multi;
   logic access;

   always_comb begin
      ce_v = r.s2[0];
      scl_v = r.s2[1];
      si_v = r.s2[2];
      ce_rise = ce_v & ~r.ce_d;
      ce_fall = ~ce_v & r.ce_d;
      scl_rise = scl_v & ~r.scl_d;
      scl_fall = ~scl_v & r.scl_d;
      tick = (r.div == 8'(OSC_DIV - 1));
      psave = r.ps_a | r.ps_b;
      ps2 = r.ps_b;
      any_key = |r.c2;
      // Current row's columns merged into the pass image
      sampled = r.cur;
      sampled[r.row * 5 +: 5] = r.c2;
      // Unused key areas forced to zero on readout and in the multi-key check
      mask = '1;
      if (r.size == kms_pkg::KMS_SIZE_25) begin
         mask[4:0] = '0;
      end
      if (r.size == kms_pkg::KMS_SIZE_20) begin
         mask[9:0] = '0;
      end
      if (psave && !ps2) begin
         mask[24:0] = '0;
      end
      if (psave && ps2) begin
         mask[19:0] = '0;
      end
      shown = r.keys & mask;
      multi = (shown & (shown - 30'd1)) != '0;
      access = wb_cyc & wb_stb & ~r.ack;
   end

   always_comb begin
      next_r = r;
      // Two-flop synchronisers for the link and return-column pins
      next_r.s1 = {si, scl, ce};
      next_r.s2 = r.s1;
      next_r.c1 = return_column;
      next_r.c2 = r.c1;
      next_r.ce_d = ce_v;
      next_r.scl_d = scl_v;
      // Oscillator stands still in idle and hold to mimic power saving
      if (r.st == kms_pkg::KMS_IDLE || r.st == kms_pkg::KMS_HOLD || tick) begin
         next_r.div = '0;
      end else begin
         next_r.div = r.div + 8'd1;
      end

      case (r.st)
         kms_pkg::KMS_IDLE: begin
            if (any_key) begin
               next_r.st = kms_pkg::KMS_SCAN;
               next_r.t_cnt = '0;
               next_r.slot = '0;
               next_r.row = '0;
               next_r.pass = 1'b0;
               next_r.cur = '0;
            end
         end
         kms_pkg::KMS_SCAN: begin
            if (tick) begin
               next_r.t_cnt = r.t_cnt + 10'd1;
               if (r.slot == 6'(kms_pkg::KMS_ROW_T - 1)) begin
                  next_r.slot = '0;
                  next_r.cur = sampled;
                  if (r.row == 3'(kms_pkg::KMS_ROWS - 1)) begin
                     next_r.row = '0;
                     next_r.cur = '0;
                     if (!r.pass) begin
                        next_r.pass = 1'b1;
                        next_r.first = sampled;
                     end else if (sampled == r.first && sampled != '0) begin
                        next_r.keys = sampled;
                        next_r.st = kms_pkg::KMS_WAIT;
                     end else if (sampled != '0 || any_key) begin
                        // Fresh pair; timing is identical for any pin sharing
                        next_r.pass = 1'b0;
                        next_r.t_cnt = '0;
                     end else begin
                        next_r.st = kms_pkg::KMS_IDLE;
                     end
                  end else begin
                     next_r.row = r.row + 3'd1;
                  end
               end else begin
                  next_r.slot = r.slot + 6'd1;
               end
            end
         end
         kms_pkg::KMS_WAIT: begin
            if (tick) begin
               next_r.t_cnt = r.t_cnt + 10'd1;
               if (r.t_cnt == 10'(kms_pkg::KMS_REQ_T - 1)) begin
                  next_r.request = 1'b1;
                  next_r.st = kms_pkg::KMS_HOLD;
               end
            end
         end
         kms_pkg::KMS_HOLD: begin
            // Keys frozen and no scanning until the host has read them
            next_r.keys = r.keys;
         end
         default: begin
            next_r.st = kms_pkg::KMS_IDLE;
         end
      endcase

      // Serial link
      if (ce_rise) begin
         next_r.rd_mode = ~scl_v;
         next_r.wr_mode = scl_v;
         next_r.sh = {psave, shown};
         next_r.wcnt = '0;
      end
      if (r.rd_mode && ce_v && scl_fall) begin
         next_r.sh = {1'b1, r.sh[30:1]};
      end
      if (r.wr_mode && ce_v && scl_rise) begin
         next_r.wsh = {si_v, r.wsh[7:1]};
         if (r.wcnt != 8'hFF) begin
            next_r.wcnt = r.wcnt + 8'd1;
         end
      end
      if (ce_fall) begin
         next_r.rd_mode = 1'b0;
         next_r.wr_mode = 1'b0;
         if (r.rd_mode && r.st == kms_pkg::KMS_HOLD) begin
            // Power-save selects are left as they are
            next_r.request = 1'b0;
            next_r.st = kms_pkg::KMS_IDLE;
         end
         if (r.wr_mode && r.wcnt >= 8'(kms_pkg::KMS_WR_BITS)) begin
            next_r.size = r.wsh[1:0];
            next_r.ps_a = r.wsh[2];
            next_r.ps_b = r.wsh[3];
            if (!r.frame_seen) begin
               next_r.quarter = (r.wsh[7:5] == kms_pkg::KMS_FRAME_ONE);
            end
            next_r.frame_seen = 1'b1;
         end
      end

      // Scan line drive
      if (r.st == kms_pkg::KMS_SCAN) begin
         next_r.lines = 6'(1) << r.row;
      end else if (r.st == kms_pkg::KMS_HOLD && multi) begin
         next_r.lines = '1;
      end else if (psave) begin
         next_r.lines = ps2 ? 6'h30 : 6'h20;
      end else begin
         next_r.lines = '1;
      end

      // Open-drain output: enable pulls the line low
      if (r.rd_mode) begin
         next_r.oe = ~r.sh[0];
      end else if (r.wr_mode && ce_v) begin
         next_r.oe = 1'b0;
      end else begin
         next_r.oe = r.request;
      end

      // Wishbone slave, one wait state
      next_r.ack = access;
      next_r.dat = '0;
      if (access) begin
         case (wb_adr)
            kms_pkg::KMS_OFS_CONTROL: begin
               next_r.dat = {28'h000_0000, r.ps_b, r.ps_a, r.size};
               if (wb_we && wb_sel[0]) begin
                  next_r.size = wb_dat_i[kms_pkg::KMS_CTL_SIZE +: 2];
                  next_r.ps_a = wb_dat_i[kms_pkg::KMS_CTL_PS_A];
                  next_r.ps_b = wb_dat_i[kms_pkg::KMS_CTL_PS_B];
               end
            end
            kms_pkg::KMS_OFS_STATUS: begin
               next_r.dat[kms_pkg::KMS_STA_REQ] = r.request;
               next_r.dat[kms_pkg::KMS_STA_SCAN] = (r.st == kms_pkg::KMS_SCAN);
               next_r.dat[kms_pkg::KMS_STA_PS] = psave;
               next_r.dat[kms_pkg::KMS_STA_QUARTER] = r.quarter;
            end
            kms_pkg::KMS_OFS_KEYS: begin
               next_r.dat = {1'b0, psave, shown};
            end
            default: begin
               next_r.dat = '0;
            end
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
         r.s1 <= 3'h2;
         r.s2 <= 3'h2;
         r.scl_d <= 1'b1;
         r.st <= kms_pkg::KMS_IDLE;
         r.size <= kms_pkg::KMS_CTL_RESET;
         r.sh <= '1;
         r.lines <= '1;
      end else begin
         r <= next_r;
      end
   end

   assign wb_dat_o = r.dat;
   assign wb_ack = r.ack;
   assign scan_line = r.lines;
   assign so_out = 1'b0;
   assign so_oe = r.oe;
endmodule // kms_scanner

//--- hdl/kms_pkg.sv
// Summary of operation
// - Key at scan line r, return column c is key bit r*5+c+1; pressed reads 1.
// - 20-key matrix clears key bits 1..10; 25-key matrix clears bits 1..5.
// - First power-save mode clears key bits 1..25; second clears bits 1..20.
// - Chip-enable rising with serial clock low selects key-data output.
// - After bit 30 one power-save indicator bit follows: 1 in power save.
// - One scan pass over the matrix lasts 288 oscillator periods.
// - Two agreeing scans with a key pressed pull the request low at 577 periods.
// - While the request is asserted scanning halts and latched keys stay.
// - Disagreeing scans with a key still pressed start another pair of scans.
// - Scan period and request delay do not depend on the pin sharing choice.
// - Normal mode: scan lines idle high, drive patterns while scanning.
// - Host writing while request is low sees the output high while enable high.
// - A completed key-data read releases the request and rearms scanning.
// - Power save: idle lines follow the select bits; a press wakes scanning.
// - Completing a read in power save does not leave power save.
// - With several unmasked keys latched all scan lines are driven high during the hold.
// - Serially written settings take effect only at the chip-enable edge.
// - Frames accepted in any order; frame 1 first sets the quarter status bit only.
// - Press to request takes at least 577 periods, 1153 with one retry.
// - All scan timing counts are in oscillator periods.
// - Either select bit set enters power save; both clear leaves it.
package kms_pkg;
   localparam int KMS_ROWS = 6;
   localparam int KMS_COLS = 5;
   localparam int KMS_KEYS = 30;
   localparam int KMS_READ_BITS = 31;
   // Timing in oscillator periods
   localparam int KMS_SCAN_T = 288;
   localparam int KMS_ROW_T = KMS_SCAN_T / KMS_ROWS;
   localparam int KMS_REQ_T = 577;
   // Register word offsets (byte addresses)
   localparam logic [3:0] KMS_OFS_CONTROL = 4'h0;
   localparam logic [3:0] KMS_OFS_STATUS = 4'h4;
   localparam logic [3:0] KMS_OFS_KEYS = 4'h8;
   // Control field positions
   localparam int KMS_CTL_SIZE = 0;
   localparam int KMS_CTL_PS_A = 2;
   localparam int KMS_CTL_PS_B = 3;
   // Status field positions
   localparam int KMS_STA_REQ = 0;
   localparam int KMS_STA_SCAN = 1;
   localparam int KMS_STA_PS = 2;
   localparam int KMS_STA_QUARTER = 3;
   // Serial control word: [1:0] size, [2] ps_a, [3] ps_b, [7:5] frame number
   localparam int KMS_WR_BITS = 8;
   localparam logic [2:0] KMS_FRAME_ONE = 3'h1;
   localparam logic [1:0] KMS_SIZE_30 = 2'h0;
   localparam logic [1:0] KMS_SIZE_25 = 2'h1;
   localparam logic [1:0] KMS_SIZE_20 = 2'h2;
   localparam logic [1:0] KMS_CTL_RESET = 2'h0;
   typedef enum logic [1:0] {
      KMS_IDLE = 2'b00,
      KMS_SCAN = 2'b01,
      KMS_WAIT = 2'b10,
      KMS_HOLD = 2'b11
   } kms_state_t;
endpackage

//--- dv/kms_scanner_properties.sv
`timescale 1ns/1ns
module kms_scanner_chk #(
   parameter int OSC_DIV = 4
) (
   // System
   input wire logic clk,
   input wire logic rst,
   // Bus
   input wire logic wb_cyc,
   input wire logic wb_stb,
   input wire logic [31:0] wb_dat_o,
   input wire logic wb_ack,
   // Matrix and link
   input wire logic [5:0] scan_line,
   input wire logic ce,
   input wire logic scl,
   input wire logic so_out,
   input wire logic so_oe
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   int unsigned run;
   // Counts from the first one-hot scan cycle and runs on until the request; overcounting is fine as the request only needs a lower bound
   always_ff @(posedge clk or posedge rst) begin
      if (rst)
         run <= 0;
      else if (so_oe)
         run <= 0;
      else if (run != 0 || $countones(scan_line) == 1)
         run <= run + 1;
   end
   sequence write_open;
      $rose(ce) && scl ##1 ce [*5];
   endsequence
   // Chip-enable falls with the clock low only at the end of a read
   sequence read_done;
      $fell(ce) && !scl;
   endsequence
   a_ack_single: assert property (wb_ack |=> !wb_ack)
      else $error("ack held longer than one cycle");
   a_ack_answer: assert property (wb_cyc && wb_stb && !wb_ack |=> wb_ack)
      else $error("bus request not answered next cycle");
   a_ack_cause: assert property (wb_ack |-> $past(wb_cyc) && $past(wb_stb))
      else $error("ack without request");
   a_data_quiet: assert property (!wb_ack |-> wb_dat_o == 32'h0000_0000)
      else $error("read data outside ack");
   a_drain_low: assert property (so_out == 1'b0)
      else $error("open drain data not low");
   a_write_masks: assert property (write_open |-> !so_oe)
      else $error("request shown during write");
   a_hold_frozen: assert property (so_oe && $past(so_oe) |-> $stable(scan_line))
      else $error("scan lines moved during hold");
   a_req_delay: assert property ($rose(so_oe) && !ce && !$past(ce, 8) |-> run >= 577 * OSC_DIV - 2)
      else $error("request came too early");
   a_read_release: assert property (read_done |-> ##4 !so_oe [*4])
      else $error("request not released after read");
endmodule // kms_scanner_chk
bind kms_scanner kms_scanner_chk #(.OSC_DIV(OSC_DIV)) i_chk (.clk(clk), .rst(rst), .wb_cyc(wb_cyc),
   .wb_stb(wb_stb), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack), .scan_line(scan_line), .ce(ce), .scl(scl),
   .so_out(so_out), .so_oe(so_oe));

//--- dv/kms_host_model.sv
`timescale 1ns/1ns
module kms_host_model (
   // System
   input wire logic clk,
   // Link
   input wire logic so_oe,
   output logic ce,
   output logic scl,
   output logic si
);
   initial begin
      ce = 1'b0;
      scl = 1'b1;
      si = 1'b0;
   end
   // Poll slower than a retried scan plus a whole read
   localparam int POLL_CYCLES = 2000;
   task automatic poll();
      repeat (POLL_CYCLES) @(posedge clk);
   endtask
   // Four or more keys may be a phantom pattern
   function automatic logic usable(input logic [30:0] bits);
      usable = $countones(bits[29:0]) < 4;
   endfunction
   // Half of the 800 ns link clock
   task automatic half();
      repeat (4) @(posedge clk);
   endtask
   task automatic read_keys(output logic [30:0] bits);
      scl <= 1'b0;
      half();
      ce <= 1'b1;
      half();
      for (int i = 0; i < 31; i++) begin
         scl <= 1'b1;
         repeat (2) @(posedge clk);
         @(negedge clk);
         bits[i] = ~so_oe;
         repeat (2) @(posedge clk);
         scl <= 1'b0;
         half();
      end
      ce <= 1'b0;
      half();
      scl <= 1'b1;
   endtask
   task automatic write_word(input logic [7:0] w);
      half();
      ce <= 1'b1;
      half();
      for (int i = 0; i < 8; i++) begin
         scl <= 1'b0;
         si <= w[i];
         half();
         scl <= 1'b1;
         half();
      end
      ce <= 1'b0;
      half();
      // Released data line must not look like the last bit
      si <= ~si;
   endtask
endmodule // kms_host_model

//--- dv/kms_scanner_bench.sv
`timescale 1ns/1ns
module kms_scanner_bench;
   logic clk = 1'b0, rst = 1'b1, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0, ce, scl, si, so_out, so_oe, wb_ack;
   logic [3:0] wb_adr = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o, q, ctl;
   logic [5:0] scan_line;
   logic [4:0] return_column;
   logic [29:0] pressed = 30'h0000_0000;
   logic [30:0] got;
   int bad_count = 0, n_tests = 0, cycles = 0, lo, key;
   always #50 clk = ~clk;
   kms_scanner #(.OSC_DIV(1)) i_dut (.clk(clk), .rst(rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
      .wb_adr(wb_adr), .wb_sel(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack(wb_ack),
      .scan_line(scan_line), .return_column(return_column), .ce(ce), .scl(scl), .si(si), .so_out(so_out),
      .so_oe(so_oe));
   kms_host_model i_host (.clk(clk), .so_oe(so_oe), .ce(ce), .scl(scl), .si(si));
   // Key matrix: a closed key joins its driven scan line to its return column
   always_comb begin
      return_column = 5'h00;
      for (int k = 0; k < 30; k++) if (pressed[k] && scan_line[k / 5]) return_column[k % 5] = 1'b1;
   end
   function automatic logic [30:0] model(input int k, input int ps);
      model = 31'h0000_0000;
      model[k] = 1'b1;
      model[30] = ps != 0;
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] d);
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= adr;
      wb_dat_i <= d;
      @(posedge clk);
      while (wb_ack !== 1'b1) @(posedge clk);
      q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic end_of_test();
      $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 20000) begin
         bad_count++;
         end_of_test();
      end
   end
   initial begin
      void'($urandom(54));
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      wb(1'b0, 4'hC, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      // Sizes 30, 25, 20 keys, then first and second power save
      for (int s = 0; s < 5; s++) begin
         lo = s == 4 ? 20 : s == 3 ? 25 : s * 5;
         ctl = s < 3 ? s : s == 3 ? 32'h0000_0004 : 32'h0000_0008;
         wb(1'b1, 4'h0, ctl);
         wb(1'b0, 4'h0, 32'h0000_0000);
         chk(q, ctl);
         key = lo + $urandom_range(29 - lo, 0);
         pressed[key] <= 1'b1;
         if (lo > 0) pressed[lo - 1] <= 1'b1;
         for (int w = 0; w < 3 && so_oe !== 1'b1; w++) i_host.poll();
         chk(so_oe, 1'b1);
         pressed <= 30'h0000_0000;
         if (s == 0) begin
            i_host.write_word(8'h20);
            wb(1'b0, 4'h4, 32'h0000_0000);
            chk(q[3], 1'b1);
         end
         wb(1'b0, 4'h8, 32'h0000_0000);
         chk(q, {1'b0, model(key, int'(s > 2))});
         chk(scan_line, s < 3 ? 6'h3F : s == 3 ? 6'h20 : 6'h30);
         i_host.read_keys(got);
         chk(got, model(key, int'(s > 2)));
         repeat (10) @(posedge clk);
         chk(so_oe, 1'b0);
         wb(1'b0, 4'h4, 32'h0000_0000);
         chk(q[2], s > 2);
      end
      // Four keys on the live lines of the second power save
      pressed <= 30'h1450_0000;
      for (int w = 0; w < 3 && so_oe !== 1'b1; w++) i_host.poll();
      chk(so_oe, 1'b1);
      pressed <= 30'h0000_0000;
      chk(scan_line, 6'h3F);
      i_host.read_keys(got);
      chk(got, 31'h5450_0000);
      chk(i_host.usable(got), 1'b0);
      end_of_test();
   end
endmodule // kms_scanner_bench
